// file: core/vpm_pkg.sv
// constants, types and helper functions shared by the page map translator
// assumes one 200 MHz clock; no software register bus reaches this block

// =============================================
// package
package vpm_pkg;

	// widths of addresses, table and entries
	localparam int ADDR_W = 32;
	localparam int PA_W = 40;
	localparam int IDX_W = 16;
	localparam int TBL_DEPTH = 65536;
	localparam int ENT_W = 32;
	localparam int HAM_W = 6;
	localparam int ECC_W = 7;
	localparam int CW_W = ENT_W + ECC_W;
	localparam int HAM_LAST_POS = 38;

	// entry fields
	localparam int VALID_BIT = 31;
	localparam int PFN_W_34 = 25;
	localparam int PFN_W_512 = 30;
	localparam int PFN_W_4K = 27;
	localparam int PFN_W_8K = 26;

	// page offsets and window limits
	localparam int SHIFT_512 = 9;
	localparam int SHIFT_4K = 12;
	localparam int SHIFT_8K = 13;
	localparam int TOP_NONE = 29;

	// timing of one lookup, in clock cycles after the request edge
	localparam int LOOKUP_CYC = 2;

	// translation mode codes
	typedef enum logic [2:0] {
		MODE_NONE = 3'h0,
		MODE_34 = 3'h1,
		MODE_40_512 = 3'h2,
		MODE_40_4K = 3'h3,
		MODE_40_8K = 3'h4
	} vpm_mode_t;

	// abort cause codes
	typedef enum logic [1:0] {
		CAUSE_NONE = 2'h0,
		CAUSE_RANGE = 2'h1,
		CAUSE_INVALID = 2'h2,
		CAUSE_UNCORR = 2'h3
	} vpm_cause_t;

	// page offset width per mode; unmapped modes pass the low window
	function automatic int vpm_shift_fn(input vpm_mode_t m);
		case (m)
			MODE_34: return SHIFT_512;
			MODE_40_512: return SHIFT_512;
			MODE_40_4K: return SHIFT_4K;
			MODE_40_8K: return SHIFT_8K;
			default: return TOP_NONE;
		endcase
	endfunction

	// frame number width per mode
	function automatic int vpm_pfn_w_fn(input vpm_mode_t m);
		case (m)
			MODE_34: return PFN_W_34;
			MODE_40_512: return PFN_W_512;
			MODE_40_4K: return PFN_W_4K;
			MODE_40_8K: return PFN_W_8K;
			default: return 0;
		endcase
	endfunction

	// lowest vme address bit that must be zero
	function automatic int vpm_top_fn(input vpm_mode_t m);
		if (vpm_pfn_w_fn(m) == 0)
			return TOP_NONE;
		return vpm_shift_fn(m) + IDX_W;
	endfunction

	// hamming check bits plus overall parity of a 32 bit entry
	function automatic logic [ECC_W-1:0] vpm_ecc_fn(input logic [ENT_W-1:0] data);
		logic [ECC_W-1:0] c;
		int d;
		c = '0;
		d = 0;
		for (int p = 1; p <= HAM_LAST_POS; p++)
			if ((p & (p - 1)) != 0)
			begin
				for (int b = 0; b < HAM_W; b++)
					if (p[b])
						c[b] = c[b] ^ data[d];
				d++;
			end
		c[HAM_W] = ^{data, c[HAM_W-1:0]};
		return c;
	endfunction

	// flip the data bit that sits at codeword position syn
	function automatic logic [ENT_W-1:0] vpm_correct_fn(input logic [ENT_W-1:0] data,
		input logic [HAM_W-1:0] syn);
		logic [ENT_W-1:0] r;
		int d;
		r = data;
		d = 0;
		for (int p = 1; p <= HAM_LAST_POS; p++)
			if ((p & (p - 1)) != 0)
			begin
				if (p == int'(syn))
					r[d] = ~r[d];
				d++;
			end
		return r;
	endfunction

endpackage

// file: core/vpm_table_mem.sv
// page map table storage: one entry and its check bits per index
// assumes writes come from the table loader and reads from the translator

`timescale 1ns/1ps

// =============================================
// memory
module vpm_table_mem
	import vpm_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// write port
	input wire logic wr_en_in,
	input wire logic [IDX_W-1:0] wr_idx_in,
	input wire logic [CW_W-1:0] wr_data_in,
	// read port, data one cycle after the enable
	input wire logic rd_en_in,
	input wire logic [IDX_W-1:0] rd_idx_in,
	output logic [CW_W-1:0] rd_data_out
);

	logic [CW_W-1:0] mem [TBL_DEPTH];
	logic [CW_W-1:0] rd_q;
	logic [CW_W-1:0] rd_d;

	// array write, no reset on storage
	always_ff @(posedge clk_in)
		if (wr_en_in)
			mem[wr_idx_in] <= wr_data_in;

	// read data holds until the next read
	always_comb
	begin
		rd_d = rd_q;
		if (rd_en_in)
			rd_d = mem[rd_idx_in];
	end

	always_ff @(posedge clk_in or posedge rst_in)
		if (rst_in)
			rd_q <= '0;
		else
			rd_q <= rd_d;

	assign rd_data_out = rd_q;

endmodule

// file: core/vpm_translator.sv
// vme dma address translator: vme address in, 40 bit system address out
// assumes requests and table writes synchronous to clk_in
//
// Overview of operation
// - 34-bit mode: pa 39:34 zero, 33:9 entry 24:0, 8:0 vme.
// - modes: none, 34-bit, 40-bit with 512, 4K or 8K pages.
// - table holds 64K entries in every mapped mode.
// - 40-bit 512-byte pages index with vme bits 24:9.
// - 40-bit 512-byte pages need vme bits 31:25 zero.
// - 40-bit 512: pa 39 zero, 38:9 entry 29:0, 8:0 vme.
// - entry bit 31 clear means invalid; abort the access.
// - ecc check entry; correctable goes on, uncorrectable aborts.
// - 40-bit 4K pages index with vme bits 27:12.
// - 40-bit 4K pages need vme bits 31:28 zero.
// - 40-bit 4K: pa 39 zero, 38:12 entry 26:0, 11:0 vme.
// - 40-bit 8K pages index with vme bits 28:13.
// - 40-bit 8K pages need vme bits 31:29 zero.
// - 40-bit 8K: pa 39 zero, 38:13 entry 25:0, 12:0 vme.
// - reset selects no translation; 3-bit mode field chosen by software.
// - no translation: vme 31:29 zero, pass 28:0, pa 39:29 zero.
// - 34-bit mode needs vme 31:25 zero, indexes with bits 24:9.

`timescale 1ns/1ps

// =============================================
// translator
module vpm_translator
	import vpm_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// mode selection
	input wire logic mode_load_in,
	input wire logic [2:0] mode_sel_in,
	output logic [2:0] mode_out,
	// page map table loading
	input wire logic tbl_wr_in,
	input wire logic [IDX_W-1:0] tbl_wr_idx_in,
	input wire logic [ENT_W-1:0] tbl_wr_entry_in,
	input wire logic [ECC_W-1:0] tbl_wr_ecc_in,
	// vme dma side
	input wire logic dma_valid_in,
	input wire logic [ADDR_W-1:0] dma_addr_in,
	input wire logic dma_write_in,
	output logic dma_ready_out,
	output logic dma_berr_out,
	// system bus side
	output logic sys_valid_out,
	output logic [PA_W-1:0] sys_addr_out,
	output logic sys_write_out,
	input wire logic sys_ready_in,
	// error status
	input wire logic err_clr_in,
	output logic [1:0] err_cause_out,
	output logic [ADDR_W-1:0] err_addr_out,
	output logic ecc_corr_out
);

	// =============================================
	// state
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_FETCH = 2'h1,
		ST_ISSUE = 2'h2,
		ST_ABORT = 2'h3
	} vpm_state_t;

	vpm_state_t st_q;
	vpm_state_t st_d;
	vpm_mode_t mode_q;
	vpm_mode_t mode_d;
	vpm_mode_t rmode_q;
	vpm_mode_t rmode_d;
	logic [ADDR_W-1:0] addr_q;
	logic [ADDR_W-1:0] addr_d;
	logic wr_q;
	logic wr_d;
	logic [PA_W-1:0] pa_q;
	logic [PA_W-1:0] pa_d;
	vpm_cause_t cause_q;
	vpm_cause_t cause_d;
	logic [ADDR_W-1:0] eaddr_q;
	logic [ADDR_W-1:0] eaddr_d;
	logic corr_q;
	logic corr_d;

	// table access
	logic rd_en;
	logic [IDX_W-1:0] rd_idx;
	logic [CW_W-1:0] rd_word;
	logic [ENT_W-1:0] rd_entry;
	logic [ECC_W-1:0] rd_ecc;
	logic [ECC_W-1:0] calc_ecc;
	logic [HAM_W-1:0] syn;
	logic par_err;
	logic ecc_uncorr;
	logic [ENT_W-1:0] fixed_entry;
	logic req_take;
	logic req_range_ok;

	// =============================================
	// address arithmetic
	// upper vme bits above the mapped window must be zero
	function automatic logic range_ok_fn(input vpm_mode_t m, input logic [ADDR_W-1:0] a);
		return (a >> vpm_top_fn(m)) == '0;
	endfunction

	// table index is the 16 bits above the page offset
	function automatic logic [IDX_W-1:0] index_fn(input vpm_mode_t m,
		input logic [ADDR_W-1:0] a);
		return IDX_W'(a >> vpm_shift_fn(m));
	endfunction

	// frame number above, vme page offset below
	function automatic logic [PA_W-1:0] form_fn(input vpm_mode_t m,
		input logic [ADDR_W-1:0] a, input logic [ENT_W-1:0] e);
		logic [PA_W-1:0] page_frame_number;
		logic [PA_W-1:0] off;
		int sh;
		sh = vpm_shift_fn(m);
		page_frame_number = PA_W'(e & ((ENT_W'(1) << vpm_pfn_w_fn(m)) - ENT_W'(1)));
		off = PA_W'(a & ((ADDR_W'(1) << sh) - ADDR_W'(1)));
		return (page_frame_number << sh) | off;
	endfunction

	// =============================================
	// table
	vpm_table_mem u_table (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.wr_en_in(tbl_wr_in),
		.wr_idx_in(tbl_wr_idx_in),
		.wr_data_in({tbl_wr_ecc_in, tbl_wr_entry_in}),
		.rd_en_in(rd_en),
		.rd_idx_in(rd_idx),
		.rd_data_out(rd_word)
	);

	// ecc check and single bit repair of the fetched entry
	assign rd_entry = rd_word[ENT_W-1:0];
	assign rd_ecc = rd_word[CW_W-1:ENT_W];
	assign calc_ecc = vpm_ecc_fn(rd_entry);
	assign syn = calc_ecc[HAM_W-1:0] ^ rd_ecc[HAM_W-1:0];
	assign par_err = ^{rd_entry, rd_ecc};
	assign ecc_uncorr = (syn != '0) && !par_err;
	assign fixed_entry = par_err ? vpm_correct_fn(rd_entry, syn) : rd_entry;

	// request decode
	assign req_take = (st_q == ST_IDLE) && dma_valid_in;
	assign req_range_ok = range_ok_fn(mode_q, dma_addr_in);
	assign rd_idx = index_fn(mode_q, dma_addr_in);

	// =============================================
	// next state
	always_comb
	begin
		st_d = st_q;
		mode_d = mode_q;
		rmode_d = rmode_q;
		addr_d = addr_q;
		wr_d = wr_q;
		pa_d = pa_q;
		cause_d = cause_q;
		eaddr_d = eaddr_q;
		corr_d = corr_q;
		rd_en = 1'b0;
		// reserved codes fall back to no translation
		if (mode_load_in)
			mode_d = vpm_mode_t'(mode_sel_in);
		// clear first so that a new event in the same cycle wins
		if (err_clr_in)
		begin
			cause_d = CAUSE_NONE;
			corr_d = 1'b0;
		end
		case (st_q)
			ST_IDLE:
				if (dma_valid_in)
				begin
					addr_d = dma_addr_in;
					wr_d = dma_write_in;
					rmode_d = mode_q;
					if (!req_range_ok)
					begin
						st_d = ST_ABORT;
						cause_d = CAUSE_RANGE;
						eaddr_d = dma_addr_in;
					end
					else if (vpm_pfn_w_fn(mode_q) == 0)
					begin
						pa_d = form_fn(mode_q, dma_addr_in, '0);
						st_d = ST_ISSUE;
					end
					else
					begin
						rd_en = 1'b1;
						st_d = ST_FETCH;
					end
				end
			ST_FETCH:
				// uncorrectable data makes the valid bit meaningless
				if (ecc_uncorr)
				begin
					st_d = ST_ABORT;
					cause_d = CAUSE_UNCORR;
					eaddr_d = addr_q;
				end
				else if (!fixed_entry[VALID_BIT])
				begin
					st_d = ST_ABORT;
					cause_d = CAUSE_INVALID;
					eaddr_d = addr_q;
				end
				else
				begin
					pa_d = form_fn(rmode_q, addr_q, fixed_entry);
					st_d = ST_ISSUE;
					if (par_err)
						corr_d = 1'b1;
				end
			ST_ISSUE:
				if (sys_ready_in)
					st_d = ST_IDLE;
			ST_ABORT:
				st_d = ST_IDLE;
			default:
				st_d = ST_IDLE;
		endcase
	end

	// registers
	always_ff @(posedge clk_in or posedge rst_in)
		if (rst_in)
		begin
			st_q <= ST_IDLE;
			mode_q <= MODE_NONE;
			rmode_q <= MODE_NONE;
			addr_q <= '0;
			wr_q <= 1'b0;
			pa_q <= '0;
			cause_q <= CAUSE_NONE;
			eaddr_q <= '0;
			corr_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			mode_q <= mode_d;
			rmode_q <= rmode_d;
			addr_q <= addr_d;
			wr_q <= wr_d;
			pa_q <= pa_d;
			cause_q <= cause_d;
			eaddr_q <= eaddr_d;
			corr_q <= corr_d;
		end

	// =============================================
	// outputs
	assign dma_ready_out = (st_q == ST_IDLE);
	assign dma_berr_out = (st_q == ST_ABORT);
	assign sys_valid_out = (st_q == ST_ISSUE);
	assign sys_addr_out = pa_q;
	assign sys_write_out = wr_q;
	assign mode_out = mode_q;
	assign err_cause_out = cause_q;
	assign err_addr_out = eaddr_q;
	assign ecc_corr_out = corr_q;

	// =============================================
	// checks
	localparam int LK = LOOKUP_CYC;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	// a mapped request ends in issue or bus error a fixed time later
	sequence s_mapped_req;
		req_take && req_range_ok && (vpm_pfn_w_fn(mode_q) != 0);
	endsequence

	sequence s_lookup_end;
		##LK (sys_valid_out || dma_berr_out);
	endsequence

	property p_lookup_time;
		s_mapped_req |-> s_lookup_end;
	endproperty
	a_lookup_time: assert property (p_lookup_time)
		else $error("lookup did not finish on time");

	property p_range_abort;
		req_take && !req_range_ok |=> dma_berr_out && (err_cause_out == CAUSE_RANGE)
			&& !sys_valid_out;
	endproperty
	a_range_abort: assert property (p_range_abort)
		else $error("out of window address not aborted");

	property p_4k_window;
		req_take && (mode_q == MODE_40_4K) && (dma_addr_in[31:28] != 4'h0) |=> dma_berr_out;
	endproperty
	a_4k_window: assert property (p_4k_window)
		else $error("4K window check failed");

	property p_8k_index;
		req_take && (mode_q == MODE_40_8K) |-> rd_idx == dma_addr_in[28:13];
	endproperty
	a_8k_index: assert property (p_8k_index)
		else $error("8K index wrong");

	property p_512_index;
		req_take && (mode_q == MODE_40_512) |-> rd_idx == dma_addr_in[24:9];
	endproperty
	a_512_index: assert property (p_512_index)
		else $error("512 index wrong");

	property p_no_xlat;
		req_take && req_range_ok && (mode_q == MODE_NONE) |=> sys_valid_out
			&& (sys_addr_out == {11'h0, $past(dma_addr_in[28:0])});
	endproperty
	a_no_xlat: assert property (p_no_xlat)
		else $error("pass through address wrong");

	property p_invalid;
		(st_q == ST_FETCH) && !ecc_uncorr && !fixed_entry[VALID_BIT] |=> dma_berr_out
			&& (err_cause_out == CAUSE_INVALID);
	endproperty
	a_invalid: assert property (p_invalid)
		else $error("invalid entry not aborted");

	property p_uncorr;
		(st_q == ST_FETCH) && ecc_uncorr |=> dma_berr_out && (err_cause_out == CAUSE_UNCORR);
	endproperty
	a_uncorr: assert property (p_uncorr)
		else $error("uncorrectable entry not aborted");

	property p_34_form;
		(st_q == ST_FETCH) && (rmode_q == MODE_34) && !ecc_uncorr && fixed_entry[VALID_BIT]
			|=> sys_valid_out && (sys_addr_out[39:34] == 6'h0)
			&& (sys_addr_out[33:9] == $past(fixed_entry[24:0]))
			&& (sys_addr_out[8:0] == addr_q[8:0]);
	endproperty
	a_34_form: assert property (p_34_form)
		else $error("34-bit address wrong");

	property p_8k_form;
		(st_q == ST_FETCH) && (rmode_q == MODE_40_8K) && !ecc_uncorr && fixed_entry[VALID_BIT]
			|=> !sys_addr_out[39] && (sys_addr_out[38:13] == $past(fixed_entry[25:0]))
			&& (sys_addr_out[12:0] == addr_q[12:0]);
	endproperty
	a_8k_form: assert property (p_8k_form)
		else $error("8K address wrong");

	property p_abort_once;
		dma_berr_out |-> !sys_valid_out ##1 (dma_ready_out && !dma_berr_out);
	endproperty
	a_abort_once: assert property (p_abort_once)
		else $error("abort not a single cycle");

	property p_mode_hold;
		!mode_load_in |=> $stable(mode_out);
	endproperty
	a_mode_hold: assert property (p_mode_hold)
		else $error("mode changed without load");

endmodule

// file: tb/vpm_sys_model.sv
// system bus responder model for the page map translator bench
// assumes the translator holds each request until it is accepted
`timescale 1ns/1ps

// =============================================
// responder
module vpm_sys_model
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// pacing and handshake
	input wire logic slow_in,
	input wire logic sys_valid_in,
	output logic sys_ready_out = 1'b0
);
	logic [3:0] pat_q = 4'h9;

	// stall pattern moves each falling edge so accept moments vary
	always @(negedge clk_in)
	begin
		pat_q <= {pat_q[2:0], pat_q[3] ^ pat_q[2]};
		sys_ready_out <= !rst_in && (!slow_in || (pat_q[0] && sys_valid_in));
	end
endmodule

// file: tb/vpm_translator_tb.sv
// self-checking bench for the page map translator
// assumes vpm_pkg, the design files and the responder model compile first
`timescale 1ns/1ps

// =============================================
// bench top
module vpm_translator_tb
	import vpm_pkg::*;
;
	typedef struct packed {logic abort; logic [PA_W-1:0] pa; logic wr; logic corr;
		logic [1:0] cause; logic [ADDR_W-1:0] va;} vpm_exp_t;
	vpm_exp_t exp_q[$];
	vpm_exp_t got_x;
	int failures = 0;
	int checks_done = 0;
	logic [31:0] seed = 32'hca1f;
	logic corr_sticky = 1'b0;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic mode_load_in = 1'b0;
	logic [2:0] mode_sel_in = 3'h0;
	logic [2:0] mode_out;
	logic tbl_wr_in = 1'b0;
	logic [IDX_W-1:0] tbl_wr_idx_in = '0;
	logic [ENT_W-1:0] tbl_wr_entry_in = '0;
	logic [ECC_W-1:0] tbl_wr_ecc_in = '0;
	logic dma_valid_in = 1'b0;
	logic [ADDR_W-1:0] dma_addr_in = '0;
	logic dma_write_in = 1'b0;
	logic dma_ready_out, dma_berr_out, sys_valid_out, sys_write_out, sys_ready_in, ecc_corr_out;
	logic [PA_W-1:0] sys_addr_out;
	logic err_clr_in = 1'b0;
	logic [1:0] err_cause_out;
	logic [ADDR_W-1:0] err_addr_out;
	logic slow = 1'b0;

	// =============================================
	// clock, design and far side
	always #2.5 clk_in = ~clk_in;

	vpm_translator u_dut (.clk_in(clk_in), .rst_in(rst_in), .mode_load_in(mode_load_in),
		.mode_sel_in(mode_sel_in), .mode_out(mode_out), .tbl_wr_in(tbl_wr_in),
		.tbl_wr_idx_in(tbl_wr_idx_in), .tbl_wr_entry_in(tbl_wr_entry_in),
		.tbl_wr_ecc_in(tbl_wr_ecc_in), .dma_valid_in(dma_valid_in), .dma_addr_in(dma_addr_in),
		.dma_write_in(dma_write_in), .dma_ready_out(dma_ready_out), .dma_berr_out(dma_berr_out),
		.sys_valid_out(sys_valid_out), .sys_addr_out(sys_addr_out),
		.sys_write_out(sys_write_out), .sys_ready_in(sys_ready_in), .err_clr_in(err_clr_in),
		.err_cause_out(err_cause_out), .err_addr_out(err_addr_out), .ecc_corr_out(ecc_corr_out));

	vpm_sys_model u_sys (.clk_in(clk_in), .rst_in(rst_in), .slow_in(slow),
		.sys_valid_in(sys_valid_out), .sys_ready_out(sys_ready_in));

	// =============================================
	// helpers
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// translated address worked out from the mode's field layout
	function automatic logic [PA_W-1:0] exp_pa(input logic [2:0] m, input logic [31:0] a,
		input logic [31:0] e);
		case (m)
			3'h1: return {6'h0, e[24:0], a[8:0]};
			3'h2: return {1'b0, e[29:0], a[8:0]};
			3'h3: return {1'b0, e[26:0], a[11:0]};
			3'h4: return {1'b0, e[25:0], a[12:0]};
			default: return {11'h0, a[28:0]};
		endcase
	endfunction

	task automatic test_done();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		checks_done++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// one request: note the expected result, hold until taken
	task automatic issue(input logic [31:0] a, input logic [2:0] m, input logic [31:0] e,
		input logic [1:0] cause, input logic corr, input bit hold);
		logic [31:0] r;
		int n;
		r = xs();
		corr_sticky = corr_sticky | corr;
		exp_q.push_back('{cause != 2'h0, exp_pa(m, a, e), r[0], corr_sticky, cause, a});
		@(negedge clk_in);
		dma_valid_in = 1'b1;
		dma_addr_in = a;
		dma_write_in = r[0];
		n = 0;
		while (dma_ready_out !== 1'b1 && n < 50)
		begin
			@(negedge clk_in);
			n++;
		end
		if (dma_ready_out !== 1'b1)
		begin
			chk(64'h1, 64'h0, "request timeout");
			test_done();
		end
		@(posedge clk_in);
		if (!hold)
		begin
			@(negedge clk_in);
			dma_valid_in = 1'b0;
		end
	endtask

	task automatic twr(input logic [15:0] i, input logic [31:0] e, input logic [6:0] c);
		@(negedge clk_in);
		tbl_wr_in = 1'b1;
		tbl_wr_idx_in = i;
		tbl_wr_entry_in = e;
		tbl_wr_ecc_in = c;
		@(negedge clk_in);
		tbl_wr_in = 1'b0;
	endtask

	task automatic setm(input logic [2:0] m);
		@(negedge clk_in);
		mode_load_in = 1'b1;
		mode_sel_in = m;
		@(negedge clk_in);
		mode_load_in = 1'b0;
		chk(64'(mode_out), 64'(m), "mode");
	endtask

	// wait for all noted results, then clear the error cause and the corrected flag
	task automatic drain_clr();
		int n;
		n = 0;
		while (exp_q.size() != 0 && n < 100)
		begin
			@(negedge clk_in);
			n++;
		end
		if (exp_q.size() != 0)
		begin
			chk(64'h1, 64'h0, "drain timeout");
			test_done();
		end
		err_clr_in = 1'b1;
		@(negedge clk_in);
		err_clr_in = 1'b0;
		corr_sticky = 1'b0;
		chk(64'({err_cause_out, ecc_corr_out}), 64'h0, "status clear");
	endtask

	// =============================================
	// result watcher
	always @(posedge clk_in)
		if (rst_in === 1'b0 && (dma_berr_out === 1'b1 || (sys_valid_out && sys_ready_in) === 1'b1))
		begin
			if (exp_q.size() == 0)
				chk(64'h1, 64'h0, "unexpected result");
			else
			begin
				got_x = exp_q.pop_front();
				chk(64'(dma_berr_out), 64'(got_x.abort), "abort kind");
				if (got_x.abort)
					chk(64'({err_cause_out, err_addr_out}), 64'({got_x.cause, got_x.va}), "abort");
				else
					chk(64'({sys_addr_out, sys_write_out, ecc_corr_out}),
						64'({got_x.pa, got_x.wr, got_x.corr}), "system access");
			end
		end

	// =============================================
	// main sequence
	initial
	begin
		logic [31:0] a[6];
		logic [31:0] e[6];
		logic [31:0] r;
		int sh;
		repeat (20) @(posedge clk_in);
		@(negedge clk_in);
		rst_in = 1'b0;
		chk(64'({mode_out, dma_ready_out, dma_berr_out, sys_valid_out, err_cause_out, ecc_corr_out}),
			64'h20, "reset state");
		for (int k = 0; k < 4; k++)
			issue(xs() & 32'h1fffffff, 3'h0, 32'h0, 2'h0, 1'b0, k < 3);
		issue(xs() | 32'h20000000, 3'h0, 32'h0, 2'h1, 1'b0, 1'b0);
		setm(3'h5);
		issue(xs() & 32'h1fffffff, 3'h5, 32'h0, 2'h0, 1'b0, 1'b0);
		drain_clr();
		for (int m = 1; m <= 4; m++)
		begin
			setm(3'(m));
			slow = m[0];
			sh = (m < 3) ? 9 : m + 9;
			for (int k = 0; k < 6; k++)
			begin
				r = xs();
				a[k] = (xs() & ((32'h1 << sh) - 32'h1)) | (32'(16'(k * 16'h2d3b) ^ 16'hffff) << sh);
				e[k] = {k != 3, r[30:0]};
				twr(16'(a[k] >> sh), (k == 5) ? e[k] ^ 32'h1 : e[k],
					vpm_ecc_fn(e[k]) ^ ((k == 4) ? 7'h03 : 7'h00));
			end
			for (int k = 0; k < 3; k++)
				issue(a[k], 3'(m), e[k], 2'h0, 1'b0, k < 2);
			issue(a[1] | (32'h1 << (sh + 16)), 3'(m), 32'h0, 2'h1, 1'b0, 1'b0);
			issue(a[3], 3'(m), e[3], 2'h2, 1'b0, 1'b0);
			issue(a[4], 3'(m), e[4], 2'h3, 1'b0, 1'b0);
			issue(a[5], 3'(m), e[5], 2'h0, 1'b1, 1'b0);
			drain_clr();
		end
		test_done();
	end
endmodule
